// *** verilog/asc_pkg.sv ***
// Shared constants for the converter sequencer control block
package asc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int RAW_W = 12;
    localparam int RES_W = 16;
    localparam int CAL_W = 7;
    localparam int CHAN_W = 5;
    localparam int SLOT_NUM = 16;
    localparam int SLOTS_PER_REG = 6;
    localparam int LEN_W = 4;
    localparam int GROUP_W = 3;
    localparam int TRIG_W = 3;
    localparam int EXT_TRIG_NUM = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the plain register port
    localparam logic [3:0] OFS_CTRL0 = 4'h0;
    localparam logic [3:0] OFS_CTRL1 = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_SLOTS_A = 4'h3;
    localparam logic [3:0] OFS_SLOTS_B = 4'h4;
    localparam logic [3:0] OFS_SLOTS_C = 4'h5;
    localparam logic [3:0] OFS_THR_HIGH = 4'h6;
    localparam logic [3:0] OFS_THR_LOW = 4'h7;
    localparam logic [3:0] OFS_RESULT = 4'h8;
    localparam logic [3:0] OFS_CAL = 4'h9;

    ////////////////////////////////////////////////////////////////////////////
    // Control register zero fields
    localparam int C0_MON_CH_LSB = 0;
    localparam int C0_EOC_IE = 5;
    localparam int C0_WDE_IE = 6;
    localparam int C0_SCAN = 8;
    localparam int C0_MON_SINGLE = 9;
    localparam int C0_DISC = 11;
    localparam int C0_GROUP_LSB = 13;
    localparam int C0_MON_EN = 23;

    // Control register one fields
    localparam int C1_CONV_EN = 0;
    localparam int C1_CONT = 1;
    localparam int C1_CAL_START = 2;
    localparam int C1_CAL_RESET = 3;
    localparam int C1_DMA = 8;
    localparam int C1_ALIGN = 11;
    localparam int C1_TRIG_LSB = 17;
    localparam int C1_EXT_EN = 20;
    localparam int C1_SW_TRIG = 22;
    localparam int C1_RES_LSB = 24;

    // Status register fields
    localparam int ST_WDE = 0;
    localparam int ST_EOC = 1;
    localparam int ST_BUSY = 4;

    // Sequence length sits above the last slot of register A
    localparam int LEN_LSB = 20;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [2:0] TRIG_SOFTWARE = 3'h7;
    localparam logic [11:0] THR_HIGH_RESET = 12'hFFF;
    localparam logic [11:0] THR_LOW_RESET = 12'h000;

    // Resolution codes with their masks and left-alignment shifts
    localparam logic [1:0] RES_12 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_8 = 2'h2;
    localparam logic [1:0] RES_6 = 2'h3;
    localparam logic [11:0] MASK_12 = 12'hFFF;
    localparam logic [11:0] MASK_10 = 12'h3FF;
    localparam logic [11:0] MASK_8 = 12'h0FF;
    localparam logic [11:0] MASK_6 = 12'h03F;
    localparam int SHL_12 = 4;
    localparam int SHL_10 = 6;
    localparam int SHL_8 = 8;
    localparam int SHL_6 = 2;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONVERT,
        SEQ_STORE
    } asc_seq_state_type;

endpackage

// *** verilog/asc_result_path.sv ***
// Result path: calibration correction and data alignment
`timescale 1ns/1ns
module asc_result_path
    import asc_pkg::*;
#(
    parameter int RAW_WIDTH = RAW_W,
    parameter int OUT_WIDTH = RES_W,
    parameter int CAL_WIDTH = CAL_W
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic valid_i,
    input wire logic [RAW_WIDTH-1:0] raw_i,
    input wire logic [CAL_WIDTH-1:0] factor_i,
    input wire logic [1:0] res_i,
    input wire logic align_i,
    output logic valid_o,
    output logic [RAW_WIDTH-1:0] raw_o,
    output logic [OUT_WIDTH-1:0] result_o
);

    logic valid_reg, valid_next;
    logic [RAW_WIDTH-1:0] raw_reg, raw_next;
    logic [OUT_WIDTH-1:0] result_reg, result_next;

    always_comb begin
        logic [RAW_WIDTH:0] sum;
        logic [RAW_WIDTH-1:0] mask;
        logic [RAW_WIDTH-1:0] corr;
        int shl;
        mask = MASK_12;
        corr = '0;
        shl = SHL_12;
        sum = {1'b0, raw_i} + {{(RAW_WIDTH + 1 - CAL_WIDTH){1'b0}}, factor_i};
        case (res_i)
            RES_10: begin
                mask = MASK_10;
                shl = SHL_10;
            end
            RES_8: begin
                mask = MASK_8;
                shl = SHL_8;
            end
            RES_6: begin
                mask = MASK_6;
                shl = SHL_6;
            end
            default: begin
                mask = MASK_12;
                shl = SHL_12;
            end
        endcase
        // Saturate rather than wrap so a corrected full-scale stays full-scale
        if (sum > {1'b0, mask}) begin
            corr = mask;
        end else begin
            corr = sum[RAW_WIDTH-1:0] & mask;
        end
        valid_next = valid_i;
        raw_next = valid_i ? corr : raw_reg;
        result_next = result_reg;
        if (valid_i) begin
            if (align_i) begin
                result_next = OUT_WIDTH'({{(OUT_WIDTH - RAW_WIDTH){1'b0}}, corr} << shl);
            end else begin
                result_next = {{(OUT_WIDTH - RAW_WIDTH){1'b0}}, corr};
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            valid_reg <= 1'b0;
            raw_reg <= '0;
            result_reg <= '0;
        end else begin
            valid_reg <= valid_next;
            raw_reg <= raw_next;
            result_reg <= result_next;
        end
    end

    assign valid_o = valid_reg;
    assign raw_o = raw_reg;
    assign result_o = result_reg;

endmodule

// *** verilog/asc_sequencer_control.sv ***
// Converter sequencer control: registers, calibration, routine sequence, flags
// Notes on behaviour
// - Calibrate-start begins calibration, self-clears when done.
// - Correction factor applied until converter powered off.
// - Calibration-reset clears held calibration state.
// - Enable low holds block reset, analog powered down.
// - Sixteen slots, four-bit length, per-slot channel.
// - Single mode converts first-slot channel per trigger.
// - Conversion stores result, sets end flag, interrupt.
// - Writing zero clears the end-of-conversion flag.
// - Continuous mode repeats conversions without new triggers.
// - DMA enable offers every result for transfer.
// - Scan converts whole sequence, flag after last.
// - Scan plus continuous restarts sequence automatically.
// - Discontinuous converts next group per trigger, max eight.
// - Discontinuous sets end flag once per full pass.
// - Out-of-window monitored result sets threshold flag.
// - Threshold compare uses raw result before alignment.
// - Monitor checks one channel or all channels.
// - Alignment bit picks left or right, six-bit differs.
// - Rising trigger edge starts; code seven is software.
// - One DMA request per routine conversion.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module asc_sequencer_control
    import asc_pkg::*;
#(
    parameter int NUM_SLOTS = SLOT_NUM
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [EXT_TRIG_NUM-1:0] ext_trigger_i,
    output logic conv_start_o,
    output logic [CHAN_W-1:0] conv_channel_o,
    input wire logic conv_done_i,
    input wire logic [RAW_W-1:0] conv_data_i,
    output logic analog_powerdown_o,
    output logic cal_start_o,
    output logic cal_reset_o,
    input wire logic cal_done_i,
    input wire logic [CAL_W-1:0] cal_factor_i,
    output logic dma_req_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Slot decoding shared by write and read paths
    function automatic logic [3:0] slot_ofs(input int idx);
        if (idx < SLOTS_PER_REG) begin
            slot_ofs = OFS_SLOTS_C;
        end else if (idx < 2 * SLOTS_PER_REG) begin
            slot_ofs = OFS_SLOTS_B;
        end else begin
            slot_ofs = OFS_SLOTS_A;
        end
    endfunction

    function automatic int slot_lsb(input int idx);
        slot_lsb = (idx % SLOTS_PER_REG) * CHAN_W;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible state
    logic [DATA_W-1:0] ctrl0_reg, ctrl0_next;
    logic [DATA_W-1:0] ctrl1_reg, ctrl1_next;
    logic [CHAN_W-1:0] slot_reg [NUM_SLOTS];
    logic [CHAN_W-1:0] slot_next [NUM_SLOTS];
    logic [LEN_W-1:0] len_reg, len_next;
    logic [RAW_W-1:0] thr_high_reg, thr_high_next;
    logic [RAW_W-1:0] thr_low_reg, thr_low_next;
    logic [RES_W-1:0] result_reg, result_next;
    logic eoc_reg, eoc_next;
    logic wde_reg, wde_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;

    // Calibration state
    logic cal_busy_reg, cal_busy_next;
    logic [CAL_W-1:0] factor_reg, factor_next;
    logic cal_start_reg, cal_start_next;
    logic cal_reset_reg, cal_reset_next;

    // Sequencer state
    asc_seq_state_type state_reg, state_next;
    logic [LEN_W-1:0] idx_reg, idx_next;
    logic [GROUP_W-1:0] grp_reg, grp_next;
    logic conv_start_reg, conv_start_next;
    logic [CHAN_W-1:0] chan_reg, chan_next;
    logic dma_reg, dma_next;
    logic irq_reg, irq_next;
    logic powerdown_reg, powerdown_next;
    logic [EXT_TRIG_NUM-1:0] ext_prev_reg;

    // Decoded fields
    logic conv_en, cont_en, scan_en, disc_en, dma_en, ext_en, align;
    logic mon_en, mon_single;
    logic [CHAN_W-1:0] mon_ch;
    logic [GROUP_W-1:0] group_size;
    logic [TRIG_W-1:0] trig_src;
    logic [1:0] res_sel;
    logic wr_ctrl1, sw_trig, ext_edge, trigger;
    logic fmt_valid, fmt_in_valid;
    logic [RAW_W-1:0] fmt_raw;
    logic [RES_W-1:0] fmt_result;

    assign conv_en = ctrl1_reg[C1_CONV_EN];
    assign cont_en = ctrl1_reg[C1_CONT];
    assign dma_en = ctrl1_reg[C1_DMA];
    assign ext_en = ctrl1_reg[C1_EXT_EN];
    assign align = ctrl1_reg[C1_ALIGN];
    assign trig_src = ctrl1_reg[C1_TRIG_LSB +: TRIG_W];
    assign res_sel = ctrl1_reg[C1_RES_LSB +: 2];
    assign scan_en = ctrl0_reg[C0_SCAN];
    assign disc_en = ctrl0_reg[C0_DISC];
    assign mon_en = ctrl0_reg[C0_MON_EN];
    assign mon_single = ctrl0_reg[C0_MON_SINGLE];
    assign mon_ch = ctrl0_reg[C0_MON_CH_LSB +: CHAN_W];
    assign group_size = ctrl0_reg[C0_GROUP_LSB +: GROUP_W];

    ////////////////////////////////////////////////////////////////////////////
    // Trigger selection
    assign wr_ctrl1 = reg_wr_i && (reg_addr_i == OFS_CTRL1);
    assign sw_trig = wr_ctrl1 && reg_wdata_i[C1_SW_TRIG] && (trig_src == TRIG_SOFTWARE);
    // Inputs are synchronous, so a single previous-value flop is enough for the edge
    assign ext_edge = ext_en && (trig_src != TRIG_SOFTWARE)
        && ext_trigger_i[trig_src] && !ext_prev_reg[trig_src];
    assign trigger = sw_trig || ext_edge;
    assign fmt_in_valid = (state_reg == SEQ_CONVERT) && conv_done_i;

    asc_result_path u_result_path (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .valid_i(fmt_in_valid),
        .raw_i(conv_data_i),
        .factor_i(factor_reg),
        .res_i(res_sel),
        .align_i(align),
        .valid_o(fmt_valid),
        .raw_o(fmt_raw),
        .result_o(fmt_result)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and reads
    always_comb begin
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        len_next = len_reg;
        thr_high_next = thr_high_reg;
        thr_low_next = thr_low_reg;
        rdata_next = '0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            slot_next[i] = slot_reg[i];
            if (reg_wr_i && reg_addr_i == slot_ofs(i)) begin
                slot_next[i] = reg_wdata_i[slot_lsb(i) +: CHAN_W];
            end
        end
        if (reg_wr_i) begin
            if (reg_addr_i == OFS_CTRL0) begin
                ctrl0_next = reg_wdata_i;
            end else if (reg_addr_i == OFS_CTRL1) begin
                ctrl1_next = reg_wdata_i;
                // Strobe bits are kept out of storage; they act as pulses
                ctrl1_next[C1_CAL_START] = 1'b0;
                ctrl1_next[C1_CAL_RESET] = 1'b0;
                ctrl1_next[C1_SW_TRIG] = 1'b0;
            end else if (reg_addr_i == OFS_SLOTS_A) begin
                len_next = reg_wdata_i[LEN_LSB +: LEN_W];
            end else if (reg_addr_i == OFS_THR_HIGH) begin
                thr_high_next = reg_wdata_i[RAW_W-1:0];
            end else if (reg_addr_i == OFS_THR_LOW) begin
                thr_low_next = reg_wdata_i[RAW_W-1:0];
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == OFS_CTRL0) begin
                rdata_next = ctrl0_reg;
            end else if (reg_addr_i == OFS_CTRL1) begin
                rdata_next = ctrl1_reg;
                rdata_next[C1_CAL_START] = cal_busy_reg;
            end else if (reg_addr_i == OFS_STATUS) begin
                rdata_next[ST_WDE] = wde_reg;
                rdata_next[ST_EOC] = eoc_reg;
                rdata_next[ST_BUSY] = (state_reg != SEQ_IDLE);
            end else if (reg_addr_i == OFS_SLOTS_A || reg_addr_i == OFS_SLOTS_B
                || reg_addr_i == OFS_SLOTS_C) begin
                for (int i = 0; i < NUM_SLOTS; i++) begin
                    if (reg_addr_i == slot_ofs(i)) begin
                        rdata_next[slot_lsb(i) +: CHAN_W] = slot_reg[i];
                    end
                end
                if (reg_addr_i == OFS_SLOTS_A) begin
                    rdata_next[LEN_LSB +: LEN_W] = len_reg;
                end
            end else if (reg_addr_i == OFS_THR_HIGH) begin
                rdata_next[RAW_W-1:0] = thr_high_reg;
            end else if (reg_addr_i == OFS_THR_LOW) begin
                rdata_next[RAW_W-1:0] = thr_low_reg;
            end else if (reg_addr_i == OFS_RESULT) begin
                rdata_next[RES_W-1:0] = result_reg;
            end else if (reg_addr_i == OFS_CAL) begin
                rdata_next[CAL_W-1:0] = factor_reg;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl0_reg <= '0;
            ctrl1_reg <= '0;
            len_reg <= '0;
            thr_high_reg <= THR_HIGH_RESET;
            thr_low_reg <= THR_LOW_RESET;
            rdata_reg <= '0;
            ext_prev_reg <= '0;
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_reg[i] <= '0;
            end
        end else begin
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
            len_reg <= len_next;
            thr_high_reg <= thr_high_next;
            thr_low_reg <= thr_low_next;
            rdata_reg <= rdata_next;
            ext_prev_reg <= ext_trigger_i;
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_reg[i] <= slot_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration
    always_comb begin
        cal_busy_next = cal_busy_reg;
        factor_next = factor_reg;
        cal_start_next = 1'b0;
        cal_reset_next = 1'b0;
        if (!conv_en) begin
            cal_busy_next = 1'b0;
            factor_next = '0;
        end else begin
            if (cal_busy_reg && cal_done_i) begin
                cal_busy_next = 1'b0;
                factor_next = cal_factor_i;
            end
            if (wr_ctrl1 && reg_wdata_i[C1_CAL_RESET]) begin
                cal_reset_next = 1'b1;
                factor_next = '0;
            end
            // Starting while a sequence runs would corrupt results, so it is refused
            if (wr_ctrl1 && reg_wdata_i[C1_CAL_START] && !cal_busy_reg && state_reg == SEQ_IDLE) begin
                cal_busy_next = 1'b1;
                cal_start_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cal_busy_reg <= 1'b0;
            factor_reg <= '0;
            cal_start_reg <= 1'b0;
            cal_reset_reg <= 1'b0;
        end else begin
            cal_busy_reg <= cal_busy_next;
            factor_reg <= factor_next;
            cal_start_reg <= cal_start_next;
            cal_reset_reg <= cal_reset_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer, flags and result
    always_comb begin
        logic last;
        logic start;
        logic monitored;
        last = (idx_reg == len_reg);
        start = 1'b0;
        monitored = 1'b0;
        state_next = state_reg;
        idx_next = idx_reg;
        grp_next = grp_reg;
        chan_next = chan_reg;
        result_next = result_reg;
        eoc_next = eoc_reg;
        wde_next = wde_reg;
        dma_next = 1'b0;
        conv_start_next = 1'b0;
        powerdown_next = !conv_en;
        // Software clear first so a same-cycle hardware set below wins
        if (reg_wr_i && reg_addr_i == OFS_STATUS) begin
            if (!reg_wdata_i[ST_EOC]) begin
                eoc_next = 1'b0;
            end
            if (!reg_wdata_i[ST_WDE]) begin
                wde_next = 1'b0;
            end
        end
        case (state_reg)
            SEQ_IDLE: begin
                // Triggers during calibration are dropped, not queued
                if (trigger && conv_en && !cal_busy_reg) begin
                    start = 1'b1;
                    grp_next = '0;
                    if (!scan_en && !disc_en) begin
                        idx_next = '0;
                    end
                end
            end
            SEQ_CONVERT: begin
                if (conv_done_i) begin
                    state_next = SEQ_STORE;
                end
            end
            SEQ_STORE: begin
                if (fmt_valid) begin
                    result_next = fmt_result;
                    dma_next = dma_en;
                    monitored = mon_en && (!mon_single || chan_reg == mon_ch);
                    if (monitored && (fmt_raw > thr_high_reg || fmt_raw < thr_low_reg)) begin
                        wde_next = 1'b1;
                    end
                    state_next = SEQ_IDLE;
                    if (disc_en) begin
                        grp_next = grp_reg + 1'b1;
                        if (last) begin
                            idx_next = '0;
                            eoc_next = 1'b1;
                        end else begin
                            idx_next = idx_reg + 1'b1;
                            start = (grp_reg != group_size);
                        end
                    end else if (scan_en) begin
                        if (last) begin
                            idx_next = '0;
                            eoc_next = 1'b1;
                            start = cont_en;
                        end else begin
                            idx_next = idx_reg + 1'b1;
                            start = 1'b1;
                        end
                    end else begin
                        idx_next = '0;
                        eoc_next = 1'b1;
                        start = cont_en;
                    end
                end
            end
            default: begin
                state_next = SEQ_IDLE;
            end
        endcase
        if (start) begin
            state_next = SEQ_CONVERT;
            conv_start_next = 1'b1;
            chan_next = slot_reg[idx_next];
        end
        if (!conv_en) begin
            state_next = SEQ_IDLE;
            idx_next = '0;
            grp_next = '0;
            conv_start_next = 1'b0;
            dma_next = 1'b0;
        end
        irq_next = (eoc_next && ctrl0_reg[C0_EOC_IE]) || (wde_next && ctrl0_reg[C0_WDE_IE]);
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= SEQ_IDLE;
            idx_reg <= '0;
            grp_reg <= '0;
            chan_reg <= '0;
            result_reg <= '0;
            eoc_reg <= 1'b0;
            wde_reg <= 1'b0;
            dma_reg <= 1'b0;
            conv_start_reg <= 1'b0;
            powerdown_reg <= 1'b1;
            irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            grp_reg <= grp_next;
            chan_reg <= chan_next;
            result_reg <= result_next;
            eoc_reg <= eoc_next;
            wde_reg <= wde_next;
            dma_reg <= dma_next;
            conv_start_reg <= conv_start_next;
            powerdown_reg <= powerdown_next;
            irq_reg <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign reg_rdata_o = rdata_reg;
    assign conv_start_o = conv_start_reg;
    assign conv_channel_o = chan_reg;
    assign analog_powerdown_o = powerdown_reg;
    assign cal_start_o = cal_start_reg;
    assign cal_reset_o = cal_reset_reg;
    assign dma_req_o = dma_reg;
    assign irq_o = irq_reg;

endmodule

// *** test/asc_core_model.sv ***
// Behavioural converter core answering conversions and calibration
`timescale 1ns/1ns
module asc_core_model
    import asc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic [3:0] lat_i,
    input wire logic start_i,
    input wire logic [CHAN_W-1:0] chan_i,
    input wire logic cal_i,
    output logic done_o,
    output logic [RAW_W-1:0] data_o,
    output logic cal_done_o,
    output logic [CAL_W-1:0] factor_o
);
    int cnt = 0;
    int ccnt = 0;
    initial {done_o, data_o, cal_done_o, factor_o} = '0;
    // Idle data toggles so a stale sample never passes
    always @(posedge sys_clk_i) begin
        done_o <= cnt == 1;
        cal_done_o <= ccnt == 1;
        data_o <= cnt == 1 ? {chan_i[3:0], 8'h10} : ~data_o;
        factor_o <= ccnt == 1 ? 7'h03 : ~factor_o;
        cnt <= start_i ? int'(lat_i) : (cnt > 0 ? cnt - 1 : 0);
        ccnt <= cal_i ? 5 : (ccnt > 0 ? ccnt - 1 : 0);
    end
endmodule

// *** test/asc_sequencer_control_sva.sv ***
// Port checker for the sequencer control block
`timescale 1ns/1ns
module asc_sva
    import asc_pkg::*;
(
    input wire logic sys_clk_i, resetn_i, reg_wr_i, reg_rd_i, conv_start_o, conv_done_i,
    input wire logic analog_powerdown_o, cal_start_o, cal_reset_o, dma_req_o,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    logic c1w;
    assign c1w = reg_wr_i && reg_addr_i == OFS_CTRL1;
    // Enable dropped by the previous write; powerdown lags it by a cycle
    logic off_w;
    always_ff @(posedge sys_clk_i) off_w <= c1w && !reg_wdata_i[C1_CONV_EN];
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0) else $error("read data left");
    a_pd_off: assert property (c1w && !reg_wdata_i[C1_CONV_EN] |-> ##[1:2] analog_powerdown_o)
        else $error("no powerdown");
    a_pd_quiet: assert property (analog_powerdown_o |-> !conv_start_o && !cal_start_o)
        else $error("start while off");
    a_start_gap: assert property (conv_start_o |=> !conv_start_o [*2]) else $error("start too soon");
    a_dma_cause: assert property (dma_req_o |-> $past(conv_done_i, 2)) else $error("stray dma");
    a_dma_pulse: assert property (dma_req_o |=> !dma_req_o) else $error("dma too long");
    a_cal_pulse: assert property (cal_start_o |=> !cal_start_o) else $error("cal too long");
    a_cal_reset: assert property (c1w && reg_wdata_i[C1_CAL_RESET] && reg_wdata_i[C1_CONV_EN]
        && !analog_powerdown_o && !off_w |=> cal_reset_o) else $error("no cal reset");
    c_dma: cover property (dma_req_o);
    c_cal: cover property (cal_start_o);
    c_off: cover property (c1w && !reg_wdata_i[C1_CONV_EN]);
endmodule
bind asc_sequencer_control asc_sva u_sva (.sys_clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .conv_start_o,
    .conv_done_i, .analog_powerdown_o, .cal_start_o, .cal_reset_o, .dma_req_o, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o);

// *** test/tb_asc_sequencer_control.sv ***
// Register-level bench for the sequencer control block
`timescale 1ns/1ns
module tb_asc_sequencer_control;
    import asc_pkg::*;
    logic clk = 0, rstn = 0, wr_s = 0, rd_s = 0, start, done, cal_s, cal_r, cal_d, dma, irq, pd;
    logic [3:0] addr = 0, lat = 2;
    logic [31:0] wdata = 0, rdata, q;
    logic [6:0] ext = 0, fac;
    logic [4:0] chan;
    logic [11:0] data;
    int n_mismatch = 0, n_checks = 0, n_dma = 0;
    asc_sequencer_control DUT (.sys_clk_i(clk), .resetn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .ext_trigger_i(ext), .conv_start_o(start),
        .conv_channel_o(chan), .conv_done_i(done), .conv_data_i(data), .analog_powerdown_o(pd),
        .cal_start_o(cal_s), .cal_reset_o(cal_r), .cal_done_i(cal_d), .cal_factor_i(fac),
        .dma_req_o(dma), .irq_o(irq));
    asc_core_model u_core (.sys_clk_i(clk), .lat_i(lat), .start_i(start), .chan_i(chan), .cal_i(cal_s),
        .done_o(done), .data_o(data), .cal_done_o(cal_d), .factor_o(fac));
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (dma === 1'b1) n_dma++;
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            n_mismatch++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1;
        @(posedge clk);
        wr_s <= 0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1;
        @(posedge clk);
        rd_s <= 0;
        @(negedge clk);
        q = rdata;
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        chk("register", q, e);
    endtask
    // Bounded poll; running out ends the run as a failure
    task automatic poll(input logic [3:0] a, input int b, input logic v);
        int i = 0;
        rd(a);
        while (q[b] !== v && i < 40) begin
            rd(a);
            i++;
        end
        if (q[b] !== v) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1;
        rc(4'h6, 32'hFFF);
        rc(4'h7, 32'h0);
        rc(4'hA, 32'h0);
        wr(4'h1, 32'h1);
        repeat (14) @(posedge clk);
        wr(4'h1, 32'h9);
        wr(4'h1, 32'hE0005);
        rc(4'h1, 32'hE0005);
        poll(4'h1, 2, 1'b0);
        rc(4'h9, 32'h3);
        wr(4'h0, 32'h800060);
        wr(4'h7, 32'h500);
        wr(4'h5, 32'h4);
        wr(4'h1, 32'h4E0101);
        poll(4'h2, 1, 1'b1);
        rc(4'h8, 32'h413);
        rc(4'h2, 32'h3);
        chk("irq", irq, 1);
        chk("dma count", n_dma, 1);
        wr(4'h2, 32'h0);
        rc(4'h2, 32'h0);
        chk("irq", irq, 0);
        wr(4'h0, 32'h100);
        wr(4'h5, 32'h18A4);
        wr(4'h3, 32'h200000);
        lat <= 6;
        wr(4'h1, 32'h4E0901);
        poll(4'h2, 1, 1'b1);
        rc(4'h2, 32'h2);
        rc(4'h8, 32'h6130);
        chk("dma count", n_dma, 4);
        wr(4'h2, 32'h0);
        wr(4'h0, 32'h800);
        wr(4'h1, 32'h100101);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            ext <= 7'h1;
            @(posedge clk);
            ext <= 7'h0;
            repeat (2) @(posedge clk);
            poll(4'h2, 4, 1'b0);
            rc(4'h2, {30'h0, k == 2, 1'b0});
            chk("dma count", n_dma, 5 + k);
        end
        rc(4'h8, 32'h613);
        wr(4'h0, 32'h0);
        wr(4'h1, 32'hE0101);
        wr(4'h1, 32'h4E0103);
        repeat (60) @(posedge clk);
        chk("repeats", n_dma > 10, 1);
        wr(4'h1, 32'h0);
        repeat (2) @(posedge clk);
        chk("powerdown", pd, 1);
        rc(4'h9, 32'h0);
        end_sim();
    end
endmodule
